// *** shared/sbst_map.svh ***
`ifndef SBST_MAP_SVH
`define SBST_MAP_SVH

// instruction register
`define SBST_IR_W        3
`define SBST_IR_EXTEST   3'h0
`define SBST_IR_IDCODE   3'h1
`define SBST_IR_SAMPLEZ  3'h2
`define SBST_IR_PRELOAD  3'h4
`define SBST_IR_BYPASS   3'h7
`define SBST_IR_CAPTURE  2'h1

// scan register sizes
`define SBST_BSR_LEN     89
`define SBST_RING_W      88
`define SBST_OE_CELL     88
`define SBST_ID_W        32

// id fields: rev 000, depth 01011, type 001000, width 100111,
// vendor field arbitrary, presence bit 1
`define SBST_IDCODE      32'h0B2272AB

// reset values
`define SBST_OE_RESET    1'h1
`define SBST_TMS_RESET   2'h3

// controller reset by tms high
`define SBST_TMS_EDGES   3'h5

// snapshot buffer
`define SBST_FIFO_DEPTH  32

`endif

// *** shared/sbst_pkg.sv ***
package sbst_pkg;

  typedef enum logic [3:0] {
    st_tlr, st_rti,
    st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr, st_pa_dr, st_ex2_dr,
    st_upd_dr,
    st_sel_ir, st_cap_ir, st_sh_ir, st_ex1_ir, st_pa_ir, st_ex2_ir,
    st_upd_ir
  } sbst_state_t;

  typedef enum logic [1:0] {
    sel_bypass, sel_ident, sel_bound
  } sbst_dr_sel_t;

endpackage

// *** shared/sbst_tap_if.sv ***
`timescale 1ns/1ps
interface sbst_tap_if;
  logic                  rise;
  logic                  tms;
  sbst_pkg::sbst_state_t state;

  modport fsm  (input rise, input tms, output state);
  modport core (output rise, output tms, input state);
endinterface

// *** rtl/sbst_fifo.sv ***
`timescale 1ns/1ps
module sbst_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic      [WIDTH-1:0] o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             rdy_reg;
  logic             val_reg;
  wire              push = i_valid & rdy_reg;
  wire              pop  = val_reg & i_ready;

  function automatic logic [AW-1:0] wrap_f(input logic [AW-1:0] p);
    wrap_f = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign o_ready  = rdy_reg;
  assign o_valid  = val_reg;
  assign o_data   = mem[rd_ptr_reg];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
      rdy_reg    <= 1'b1;
      val_reg    <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wrap_f(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= wrap_f(rd_ptr_reg);
      end
      cnt_reg <= cnt_next;
      rdy_reg <= cnt_next != (AW+1)'(DEPTH);
      val_reg <= cnt_next != '0;
    end
  end

  fifo_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cnt_reg <= (AW+1)'(DEPTH) && (rdy_reg == (cnt_reg != (AW+1)'(DEPTH))))
    else $error("fifo count out of range");
endmodule

// *** rtl/sbst_fsm.sv ***
`timescale 1ns/1ps
`include "sbst_map.svh"
module sbst_fsm (
  input  wire logic i_clk,
  input  wire logic i_rst,
  sbst_tap_if.fsm   tap
);
  sbst_pkg::sbst_state_t state_reg;
  sbst_pkg::sbst_state_t state_next;
  sbst_pkg::sbst_state_t step;
  logic [2:0]            high_cnt_reg;

  assign tap.state = state_reg;

  // ****************************************
  // sixteen-state controller
  // ****************************************
  always_comb begin
    case (state_reg)
      sbst_pkg::st_tlr:    step = tap.tms ? sbst_pkg::st_tlr
                                          : sbst_pkg::st_rti;
      sbst_pkg::st_rti:    step = tap.tms ? sbst_pkg::st_sel_dr
                                          : sbst_pkg::st_rti;
      sbst_pkg::st_sel_dr: step = tap.tms ? sbst_pkg::st_sel_ir
                                          : sbst_pkg::st_cap_dr;
      sbst_pkg::st_cap_dr: step = tap.tms ? sbst_pkg::st_ex1_dr
                                          : sbst_pkg::st_sh_dr;
      sbst_pkg::st_sh_dr:  step = tap.tms ? sbst_pkg::st_ex1_dr
                                          : sbst_pkg::st_sh_dr;
      sbst_pkg::st_ex1_dr: step = tap.tms ? sbst_pkg::st_upd_dr
                                          : sbst_pkg::st_pa_dr;
      sbst_pkg::st_pa_dr:  step = tap.tms ? sbst_pkg::st_ex2_dr
                                          : sbst_pkg::st_pa_dr;
      sbst_pkg::st_ex2_dr: step = tap.tms ? sbst_pkg::st_upd_dr
                                          : sbst_pkg::st_sh_dr;
      sbst_pkg::st_upd_dr: step = tap.tms ? sbst_pkg::st_sel_dr
                                          : sbst_pkg::st_rti;
      sbst_pkg::st_sel_ir: step = tap.tms ? sbst_pkg::st_tlr
                                          : sbst_pkg::st_cap_ir;
      sbst_pkg::st_cap_ir: step = tap.tms ? sbst_pkg::st_ex1_ir
                                          : sbst_pkg::st_sh_ir;
      sbst_pkg::st_sh_ir:  step = tap.tms ? sbst_pkg::st_ex1_ir
                                          : sbst_pkg::st_sh_ir;
      sbst_pkg::st_ex1_ir: step = tap.tms ? sbst_pkg::st_upd_ir
                                          : sbst_pkg::st_pa_ir;
      sbst_pkg::st_pa_ir:  step = tap.tms ? sbst_pkg::st_ex2_ir
                                          : sbst_pkg::st_pa_ir;
      sbst_pkg::st_ex2_ir: step = tap.tms ? sbst_pkg::st_upd_ir
                                          : sbst_pkg::st_sh_ir;
      sbst_pkg::st_upd_ir: step = tap.tms ? sbst_pkg::st_sel_dr
                                          : sbst_pkg::st_rti;
      default:             step = sbst_pkg::st_tlr;
    endcase
  end

  assign state_next = tap.rise ? step : state_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= sbst_pkg::st_tlr;
    end else begin
      state_reg <= state_next;
    end
  end

  // consecutive tms-high edges, for checking only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      high_cnt_reg <= 3'h0;
    end else if (tap.rise) begin
      if (!tap.tms) begin
        high_cnt_reg <= 3'h0;
      end else if (high_cnt_reg != `SBST_TMS_EDGES) begin
        high_cnt_reg <= high_cnt_reg + 3'h1;
      end
    end
  end

  tms_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
    high_cnt_reg == `SBST_TMS_EDGES |-> state_reg == sbst_pkg::st_tlr)
    else $error("five tms-high edges did not reach reset state");

  fsm_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
    tap.rise && state_reg == sbst_pkg::st_sh_dr && !tap.tms
    |=> state_reg == sbst_pkg::st_sh_dr)
    else $error("shift-dr left with tms low");
endmodule

// *** rtl/sbst_tap.sv ***
`timescale 1ns/1ps
`include "sbst_map.svh"
module sbst_tap #(
  parameter int unsigned            FIFO_DEPTH = `SBST_FIFO_DEPTH,
  // vendor field of this code is arbitrary
  parameter logic [`SBST_ID_W-1:0]  ID_CODE    = `SBST_IDCODE
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_tck,
  input  wire logic                    i_tms,
  input  wire logic                    i_tdi,
  input  wire logic [`SBST_RING_W-1:0] i_ring_data,
  input  wire logic                    i_ring_valid,
  output logic                         o_ring_ready,
  output logic                         o_tdo,
  output logic                         o_tdo_oe,
  output logic      [`SBST_RING_W-1:0] o_pre_data,
  output logic                         o_extest,
  output logic                         o_q_drive_en,
  output logic                         o_q_hiz
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] tck_sync_reg;
  logic       tck_prev_reg;
  logic [1:0] tms_sync_reg;
  logic [1:0] tdi_sync_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tck_sync_reg <= 2'h0;
      tck_prev_reg <= 1'b0;
      tms_sync_reg <= `SBST_TMS_RESET;
      tdi_sync_reg <= `SBST_TMS_RESET;
    end else begin
      tck_sync_reg <= {tck_sync_reg[0], i_tck};
      tck_prev_reg <= tck_sync_reg[1];
      tms_sync_reg <= {tms_sync_reg[0], i_tms};
      tdi_sync_reg <= {tdi_sync_reg[0], i_tdi};
    end
  end

  wire tck_rise = tck_sync_reg[1] & ~tck_prev_reg;
  wire tck_fall = ~tck_sync_reg[1] & tck_prev_reg;
  wire tdi      = tdi_sync_reg[1];

  // ****************************************
  // controller
  // ****************************************
  sbst_tap_if tap_if ();

  assign tap_if.rise = tck_rise;
  assign tap_if.tms  = tms_sync_reg[1];

  sbst_fsm u_fsm (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .tap   (tap_if)
  );

  sbst_pkg::sbst_state_t st;
  assign st = tap_if.state;

  wire in_tlr  = st == sbst_pkg::st_tlr;
  wire cap_ir  = tck_rise & (st == sbst_pkg::st_cap_ir);
  wire sh_ir   = tck_rise & (st == sbst_pkg::st_sh_ir);
  wire upd_ir  = tck_rise & (st == sbst_pkg::st_upd_ir);
  wire cap_dr  = tck_rise & (st == sbst_pkg::st_cap_dr);
  wire sh_dr   = tck_rise & (st == sbst_pkg::st_sh_dr);
  wire upd_dr  = tck_rise & (st == sbst_pkg::st_upd_dr);
  wire shifting = (st == sbst_pkg::st_sh_dr) | (st == sbst_pkg::st_sh_ir);

  // ****************************************
  // instruction decode
  // ****************************************
  // reserved codes are unimplemented; they fall back to the bypass path
  function automatic sbst_pkg::sbst_dr_sel_t dr_sel_f(
    input logic [`SBST_IR_W-1:0] ir
  );
    case (ir)
      `SBST_IR_IDCODE:  dr_sel_f = sbst_pkg::sel_ident;
      `SBST_IR_EXTEST,
      `SBST_IR_SAMPLEZ,
      `SBST_IR_PRELOAD: dr_sel_f = sbst_pkg::sel_bound;
      default:          dr_sel_f = sbst_pkg::sel_bypass;
    endcase
  endfunction

  logic [`SBST_IR_W-1:0] ir_reg;
  logic [`SBST_IR_W-1:0] ir_sh_reg;

  sbst_pkg::sbst_dr_sel_t dr_sel;
  assign dr_sel = dr_sel_f(ir_reg);

  wire sel_byp = dr_sel == sbst_pkg::sel_bypass;
  wire sel_id  = dr_sel == sbst_pkg::sel_ident;
  wire sel_bsr = dr_sel == sbst_pkg::sel_bound;
  wire is_ext  = ir_reg == `SBST_IR_EXTEST;
  wire is_smz  = ir_reg == `SBST_IR_SAMPLEZ;

  // ****************************************
  // instruction register
  // ****************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ir_sh_reg <= `SBST_IR_IDCODE;
      ir_reg    <= `SBST_IR_IDCODE;
    end else if (in_tlr) begin
      ir_sh_reg <= `SBST_IR_IDCODE;
      ir_reg    <= `SBST_IR_IDCODE;
    end else begin
      if (cap_ir) begin
        ir_sh_reg <= {1'b0, `SBST_IR_CAPTURE};
      end else if (sh_ir) begin
        ir_sh_reg <= {tdi, ir_sh_reg[`SBST_IR_W-1:1]};
      end
      if (upd_ir) begin
        ir_reg <= ir_sh_reg;
      end
    end
  end

  // ****************************************
  // ring snapshot buffer
  // ****************************************
  logic [`SBST_RING_W-1:0] snap_data;
  logic                    snap_valid;
  wire                     snap_take = cap_dr & sel_bsr;

  sbst_fifo #(
    .WIDTH (`SBST_RING_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_data  (i_ring_data),
    .i_valid (i_ring_valid),
    .o_ready (o_ring_ready),
    .o_data  (snap_data),
    .o_valid (snap_valid),
    .i_ready (snap_take)
  );

  // ****************************************
  // data registers
  // ****************************************
  logic                     byp_reg;
  logic [`SBST_ID_W-1:0]    id_sh_reg;
  logic [`SBST_BSR_LEN-1:0] bsr_reg;
  logic [`SBST_BSR_LEN-1:0] upd_reg;
  logic [`SBST_RING_W-1:0]  ring_cap;

  // an empty buffer leaves the ring cells as they stand
  assign ring_cap = snap_valid ? snap_data : bsr_reg[`SBST_RING_W-1:0];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      byp_reg <= 1'b0;
    end else if (cap_dr & sel_byp) begin
      byp_reg <= 1'b0;
    end else if (sh_dr & sel_byp) begin
      byp_reg <= tdi;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      id_sh_reg <= '0;
    end else if (cap_dr & sel_id) begin
      id_sh_reg <= ID_CODE;
    end else if (sh_dr & sel_id) begin
      id_sh_reg <= {tdi, id_sh_reg[`SBST_ID_W-1:1]};
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bsr_reg <= '0;
    end else if (snap_take) begin
      bsr_reg <= {upd_reg[`SBST_OE_CELL], ring_cap};
    end else if (sh_dr & sel_bsr) begin
      // captured data leaves while the preload pattern enters
      bsr_reg <= {tdi, bsr_reg[`SBST_BSR_LEN-1:1]};
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      upd_reg <= {`SBST_OE_RESET, {`SBST_RING_W{1'b0}}};
    end else if (in_tlr) begin
      upd_reg[`SBST_OE_CELL] <= `SBST_OE_RESET;
    end else if (upd_dr & sel_bsr) begin
      upd_reg <= bsr_reg;
    end
  end

  // ****************************************
  // serial output
  // ****************************************
  logic tdo_reg;
  logic tdo_oe_reg;
  logic dr_lsb;
  logic out_bit;

  assign dr_lsb  = sel_id  ? id_sh_reg[0] :
                   sel_bsr ? bsr_reg[0]   : byp_reg;
  assign out_bit = (st == sbst_pkg::st_sh_ir) ? ir_sh_reg[0] : dr_lsb;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (tck_fall) begin
      tdo_reg    <= shifting ? out_bit : 1'b0;
      tdo_oe_reg <= shifting;
    end
  end

  assign o_tdo    = tdo_reg;
  assign o_tdo_oe = tdo_oe_reg;

  // ****************************************
  // output bus control
  // ****************************************
  logic ext_reg;
  logic drive_reg;
  logic hiz_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ext_reg   <= 1'b0;
      drive_reg <= 1'b0;
      hiz_reg   <= 1'b0;
    end else begin
      ext_reg   <= is_ext;
      drive_reg <= is_ext & upd_reg[`SBST_OE_CELL];
      hiz_reg   <= is_smz | (is_ext & ~upd_reg[`SBST_OE_CELL]);
    end
  end

  assign o_extest     = ext_reg;
  assign o_q_drive_en = drive_reg;
  assign o_q_hiz      = hiz_reg;
  assign o_pre_data   = upd_reg[`SBST_RING_W-1:0];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence ext_armed_s;
    is_ext && upd_reg[`SBST_OE_CELL];
  endsequence

  sequence ext_floated_s;
    is_ext && !upd_reg[`SBST_OE_CELL];
  endsequence

  sequence bsr_shift_s;
    sh_dr && sel_bsr;
  endsequence

  ir_reset_a: assert property (
    in_tlr |=> ir_reg == `SBST_IR_IDCODE)
    else $error("instruction not reset to identification code");

  ir_capture_a: assert property (
    cap_ir && !in_tlr |=> ir_sh_reg[1:0] == `SBST_IR_CAPTURE)
    else $error("capture-ir pattern wrong");

  ir_update_a: assert property (
    $changed(ir_reg) |-> $past(upd_ir) || $past(in_tlr))
    else $error("instruction changed outside update-ir");

  byp_clear_a: assert property (
    cap_dr && sel_byp |=> !byp_reg ##1 !byp_reg || $past(sh_dr))
    else $error("bypass register not cleared");

  id_capture_a: assert property (
    cap_dr && sel_id |=> id_sh_reg == ID_CODE)
    else $error("identification code not captured");

  bsr_shift_a: assert property (
    bsr_shift_s |=> bsr_reg[`SBST_BSR_LEN-1] == $past(tdi)
      && bsr_reg[`SBST_BSR_LEN-2:0] == $past(bsr_reg[`SBST_BSR_LEN-1:1]))
    else $error("boundary shift direction wrong");

  tdo_edge_a: assert property (
    $changed(o_tdo) || $changed(o_tdo_oe) |-> $past(tck_fall))
    else $error("serial output moved off a falling edge");

  tdo_float_a: assert property (
    $rose(o_tdo_oe) |-> $past(shifting))
    else $error("serial output driven outside shift state");

  oe_preset_a: assert property (
    in_tlr |=> upd_reg[`SBST_OE_CELL])
    else $error("output enable cell not preset");

  ext_drive_a: assert property (
    ext_armed_s |=> o_q_drive_en && !o_q_hiz)
    else $error("extest enable cell not driving bus");

  ext_float_a: assert property (
    ext_floated_s |=> !o_q_drive_en && o_q_hiz)
    else $error("extest zero cell not floating bus");

  smz_hiz_a: assert property (
    is_smz |=> o_q_hiz && !o_q_drive_en)
    else $error("sample-z did not float bus");

  pre_latch_a: assert property (
    upd_dr && sel_bsr && !in_tlr |=> o_pre_data == $past(
      bsr_reg[`SBST_RING_W-1:0]))
    else $error("preload pattern not latched at update-dr");
endmodule

// *** verif/sbst_jtag_ctl.sv ***
`timescale 1ns/1ps
// ****************************************
// board test controller model
// ****************************************
module sbst_jtag_ctl (
  input  wire logic i_clk,
  input  wire logic i_tdo,
  input  wire logic i_tdo_oe,
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi
);
  // clock stands low between frames, tdi rests at its pull-up level
  initial begin
    o_tck = 1'h0;
    o_tms = 1'h1;
    o_tdi = 1'h1;
  end

  // 3 clk high, 5 clk low; tdo read just before the rise
  task automatic step(input logic m, input logic dt, output logic q,
                      output logic oe);
    @(posedge i_clk);
    q = i_tdo;
    oe = i_tdo_oe;
    o_tms <= m;
    o_tdi <= dt;
    o_tck <= 1'h1;
    repeat (3) @(posedge i_clk);
    o_tck <= 1'h0;
    repeat (4) @(posedge i_clk);
  endtask

  // from idle to exit1 through one shift
  task automatic scan(input logic ir, input int n, input logic [88:0] din,
                      output logic [88:0] dout, output logic oe_all);
    logic q;
    logic oe;
    int   i;
    dout = '0;
    oe_all = 1'h1;
    step(1'h1, 1'h1, q, oe);
    if (ir) begin
      step(1'h1, 1'h1, q, oe);
    end
    step(1'h0, 1'h1, q, oe);
    step(1'h0, 1'h1, q, oe);
    for (i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q, oe);
      dout[i] = q;
      oe_all &= oe;
    end
  endtask

  task automatic upd(output logic oe);
    logic q;
    step(1'h1, 1'h1, q, oe);
    step(1'h0, 1'h1, q, oe);
  endtask

  task automatic instr(input logic [2:0] code, output logic [2:0] capt);
    logic [88:0] o;
    logic        oe;
    if (code inside {3'h3, 3'h5, 3'h6}) begin
      code = 3'h7; // reserved codes never sent
    end
    scan(1'h1, 3, {86'h0, code}, o, oe);
    capt = o[2:0];
    upd(oe);
  endtask

  task automatic tlr();
    logic q;
    logic oe;
    repeat (5) step(1'h1, 1'h1, q, oe);
    step(1'h0, 1'h1, q, oe);
  endtask
endmodule

// *** verif/sbst_tap_tb.sv ***
`timescale 1ns/1ps
`include "sbst_map.svh"
// ****************************************
// scan port bench
// ****************************************
module sbst_tap_tb;
  logic                    clk;
  logic                    rst;
  logic                    tck;
  logic                    tms;
  logic                    tdi;
  logic [`SBST_RING_W-1:0] ring_data;
  logic                    ring_valid;
  logic                    ring_ready;
  logic                    tdo;
  logic                    tdo_oe;
  logic [`SBST_RING_W-1:0] pre_data;
  logic                    extest;
  logic                    drive_en;
  logic                    hiz;
  int                      err_total;
  int                      n_compared;
  int                      cyc;
  logic [88:0]             d;
  logic [2:0]              c;
  logic                    oe;

  sbst_tap #(.FIFO_DEPTH(4)) i_sbst_tap (
    .i_clk        (clk),
    .i_rst        (rst),
    .i_tck        (tck),
    .i_tms        (tms),
    .i_tdi        (tdi),
    .i_ring_data  (ring_data),
    .i_ring_valid (ring_valid),
    .o_ring_ready (ring_ready),
    .o_tdo        (tdo),
    .o_tdo_oe     (tdo_oe),
    .o_pre_data   (pre_data),
    .o_extest     (extest),
    .o_q_drive_en (drive_en),
    .o_q_hiz      (hiz)
  );

  sbst_jtag_ctl i_sbst_jtag_ctl (
    .i_clk    (clk),
    .i_tdo    (tdo),
    .i_tdo_oe (tdo_oe),
    .o_tck    (tck),
    .o_tms    (tms),
    .o_tdi    (tdi)
  );

  always #25 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [88:0] seen,
                     input logic [88:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [87:0] w(input int k);
    return {22{4'(k) ^ 4'h5}};
  endfunction

  task automatic t_idle();
    chk("tdo_oe", tdo_oe, 1'h0);
    chk("ready", ring_ready, 1'h1);
    chk("pre", pre_data, '0);
    chk("ext", extest, 1'h0);
    chk("hiz", hiz, 1'h0);
    chk("drv", drive_en, 1'h0);
  endtask

  task automatic t_ident();
    i_sbst_jtag_ctl.scan(1'h0, 32, '1, d, oe);
    chk("idcode", d[31:0], `SBST_IDCODE);
    chk("oe_shift", oe, 1'h1);
    i_sbst_jtag_ctl.upd(oe);
    chk("oe_idle", oe, 1'h0);
  endtask

  task automatic t_bypass();
    i_sbst_jtag_ctl.instr(`SBST_IR_BYPASS, c);
    chk("ir_capture", c, 3'b001);
    i_sbst_jtag_ctl.scan(1'h0, 4, 89'hB, d, oe);
    chk("bypass", d[3:0], 4'h6);
    i_sbst_jtag_ctl.upd(oe);
  endtask

  task automatic t_ring();
    logic [88:0] din;
    int          k;
    din = '0;
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      ring_data <= w(k);
      ring_valid <= 1'h1;
    end
    @(posedge clk);
    ring_data <= w(7);
    #1 chk("ready_full", ring_ready, 1'h0);
    repeat (3) @(posedge clk);
    ring_valid <= 1'h0;
    i_sbst_jtag_ctl.instr(`SBST_IR_PRELOAD, c);
    for (k = 0; k < 5; k++) begin
      i_sbst_jtag_ctl.scan(1'h0, 89, {1'h1, w(k + 8)}, d, oe);
      chk("snap", d[87:0], (k < 4) ? w(k) : din[87:0]);
      chk("cell_oe", d[88], 1'h1);
      i_sbst_jtag_ctl.upd(oe);
      chk("preload", pre_data, w(k + 8));
      chk("ready", ring_ready, 1'h1);
      din = {1'h1, w(k + 8)};
    end
  endtask

  task automatic t_extest();
    i_sbst_jtag_ctl.scan(1'h0, 89, {1'h0, w(3)}, d, oe);
    i_sbst_jtag_ctl.upd(oe);
    i_sbst_jtag_ctl.instr(`SBST_IR_EXTEST, c);
    chk("extest", extest, 1'h1);
    chk("ext_pre", pre_data, w(3));
    chk("ext_hiz", hiz, 1'h1);
    chk("ext_drv", drive_en, 1'h0);
    i_sbst_jtag_ctl.scan(1'h0, 89, {1'h1, w(3)}, d, oe);
    chk("ext_cap", d, {1'h0, w(3)});
    i_sbst_jtag_ctl.upd(oe);
    chk("drv_on", drive_en, 1'h1);
    chk("hiz_off", hiz, 1'h0);
    i_sbst_jtag_ctl.scan(1'h1, 3, 89'(`SBST_IR_SAMPLEZ), d, oe);
    chk("ir_held", extest, 1'h1);
    i_sbst_jtag_ctl.upd(oe);
    chk("z_hiz", hiz, 1'h1);
    chk("z_ext", extest, 1'h0);
    i_sbst_jtag_ctl.scan(1'h0, 89, '0, d, oe);
    chk("z_cap", d, {1'h1, w(3)});
    i_sbst_jtag_ctl.upd(oe);
  endtask

  task automatic t_tlr();
    i_sbst_jtag_ctl.tlr();
    chk("tlr_hiz", hiz, 1'h0);
    chk("tlr_drv", drive_en, 1'h0);
    t_ident();
    i_sbst_jtag_ctl.instr(`SBST_IR_PRELOAD, c);
    i_sbst_jtag_ctl.scan(1'h0, 89, '0, d, oe);
    chk("oe_preset", d[88], 1'h1);
    i_sbst_jtag_ctl.upd(oe);
  endtask

  initial begin
    clk = 1'h0;
    rst = 1'h1;
    ring_data = '0;
    ring_valid = 1'h0;
    err_total = 0;
    n_compared = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    repeat (4) @(posedge clk);
    t_idle();
    // walk the controller from reset state to idle
    i_sbst_jtag_ctl.tlr();
    t_ident();
    t_bypass();
    t_ring();
    t_extest();
    t_tlr();
    tally_and_finish();
  end
endmodule
